// ==== boot_drive_model.sv ====
`timescale 1ns/1ns
module boot_drive_model
   import boot_load_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Selects and commands from the sequencer.
   input wire logic disk_boot_select_n,
   input wire logic diskette_boot_select_n,
   input wire disk_cmd_t disk_cmd,
   input wire dskt_cmd_word_t dskt_cmd,
   // Pacing and byte pattern chosen by the bench.
   input wire logic slow,
   input wire logic [7:0] seed_byte,
   // Read stream toward the sequencer.
   output logic rd_valid,
   output logic [7:0] rd_data
);
   int n;
   logic run;
   logic odd;
   wire stream_on = !disk_boot_select_n || !diskette_boot_select_n;

   // Streams only after a read command and only while a select is low.
   // Idle data toggles every cycle so a stale byte can never look valid.
   always @(negedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         run <= 1'b0;
         n <= 0;
         odd <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h5A;
      end else begin
         odd <= ~odd;
         if (!stream_on) begin
            run <= 1'b0;
         end else if (disk_cmd.valid && !disk_boot_select_n) begin
            run <= 1'b1;
         end else if (dskt_cmd.valid && dskt_cmd.code == DSKT_CMD_READ) begin
            run <= 1'b1;
         end
         if (run && stream_on && !(slow && odd)) begin
            rd_valid <= 1'b1;
            rd_data <= seed_byte ^ n[7:0];
            n <= n + 1;
         end else begin
            rd_valid <= 1'b0;
            rd_data <= ~rd_data;
            if (!stream_on) n <= 0;
         end
      end
   end
endmodule : boot_drive_model

// ==== boot_load_pkg.sv ====
package boot_load_pkg;

   // Boot image size and control storage layout.
   localparam int CS_ADDR_W = 12;
   localparam int CS_COUNT_W = 13;
   localparam logic [CS_COUNT_W-1:0] CS_BOOT_BYTES = 13'h1000;
   localparam logic [CS_COUNT_W-1:0] CS_LAST_BYTE = CS_BOOT_BYTES - 13'h0001;
   localparam logic [CS_ADDR_W-1:0] CS_START_ADDR = 12'h000;
   localparam logic [CS_COUNT_W-1:0] CS_COUNT_STEP = 13'h0001;

   // Disk boot read: one read-data command for 16 records from record 0.
   localparam logic [4:0] DISK_RECORD_COUNT = 5'h10;
   localparam logic [7:0] DISK_START_RECORD = 8'h00;
   localparam logic [7:0] DISK_START_CYL = 8'h00;
   localparam logic [3:0] DISK_START_HEAD = 4'h0;

   // Diskette boot read position.
   localparam logic [7:0] DSKT_START_CYL = 8'h00;
   localparam logic [3:0] DSKT_START_HEAD = 4'h0;
   localparam logic [7:0] DSKT_START_SECTOR = 8'h01;

   // Diskette adapter command codes and the order in which they are sent.
   typedef enum logic [1:0] {
      DSKT_CMD_NONE = 2'h0,
      DSKT_CMD_RECAL = 2'h1,
      DSKT_CMD_LOAD_HEADS = 2'h2,
      DSKT_CMD_READ = 2'h3
   } dskt_cmd_t;

   // Active level of the panel display indication; reset loads its inverse.
   localparam logic LOADING_SHOWN = 1'b1;

   // Sequencer states, one-hot.
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_REQ = 7'h02,
      S_LOAD = 7'h04,
      S_DESEL = 7'h08,
      S_PCB_RESET = 7'h10,
      S_PCB_START = 7'h20,
      S_CLEAR = 7'h40
   } seq_state_t;

   // Control storage write port.
   typedef struct packed {
      logic we;
      logic [CS_ADDR_W-1:0] addr;
      logic [7:0] data;
   } cs_write_t;

   // Disk read-data command.
   typedef struct packed {
      logic valid;
      logic [4:0] records;
      logic [7:0] start_record;
      logic [7:0] cylinder;
      logic [3:0] head;
   } disk_cmd_t;

   // Diskette command.
   typedef struct packed {
      logic valid;
      dskt_cmd_t code;
      logic [7:0] cylinder;
      logic [3:0] head;
      logic [7:0] sector;
   } dskt_cmd_word_t;

endpackage : boot_load_pkg

// ==== boot_load_sequencer.sv ====
`timescale 1ns/1ns
module boot_load_sequencer
   import boot_load_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Panel side.
   input wire logic load_start,
   input wire logic boot_from_diskette,
   output logic loading_display,
   // Adapter reset pins, active low, asynchronous.
   input wire logic disk_dskt_reset_n,
   input wire logic power_on_reset_n,
   // Boot data stream from the adapter read path.
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   // Load handshake lines.
   output logic load_cycle_request_n,
   output logic disk_boot_select_n,
   output logic diskette_boot_select_n,
   // Control storage write port.
   output cs_write_t cs_write,
   // Drive commands.
   output disk_cmd_t disk_cmd,
   output dskt_cmd_word_t dskt_cmd,
   // Control processor commands.
   output logic processor_control_bit_reset,
   output logic processor_control_bit_start,
   output logic [CS_ADDR_W-1:0] control_processor_start_addr
);

   typedef struct packed {
      seq_state_t st;
      logic from_dskt;
      logic [CS_COUNT_W-1:0] count;
      logic lcr_n;
      logic disk_sel_n;
      logic dskt_sel_n;
      cs_write_t csw;
      logic disk_armed;
      logic disk_sent;
      disk_cmd_t dcmd;
      logic dskt_armed;
      dskt_cmd_t dskt_next;
      dskt_cmd_word_t kcmd;
      logic pcb_reset;
      logic pcb_start;
      logic [CS_ADDR_W-1:0] start_addr;
      logic display;
   } state_t;

   state_t q;
   state_t d;
   logic [1:0] rst_pins_s;
   logic disk_rst_s;
   logic por_s;
   logic sel_active;

   // Both reset pins come from outside the clock domain.
   pin_sync2 #(.W(2), .INIT(2'h3)) u_pin_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in({disk_dskt_reset_n, power_on_reset_n}),
      .sync_out(rst_pins_s)
   );
   assign disk_rst_s = rst_pins_s[1];
   assign por_s = rst_pins_s[0];
   assign sel_active = !q.disk_sel_n || !q.dskt_sel_n;

   // Next-state logic for the panel sequencer and both adapters.
   always_comb begin
      d = q;
      d.csw.we = 1'b0;
      d.dcmd.valid = 1'b0;
      d.kcmd.valid = 1'b0;
      d.pcb_reset = 1'b0;
      d.pcb_start = 1'b0;
      unique case (q.st)
         S_IDLE: begin
            if (load_start) begin
               d.lcr_n = 1'b0;
               d.display = 1'b1;
               d.from_dskt = boot_from_diskette;
               d.count = '0;
               d.disk_sent = 1'b0;
               d.dskt_next = DSKT_CMD_RECAL;
               d.st = S_REQ;
            end
         end
         S_REQ: begin
            d.disk_sel_n = q.from_dskt;
            d.dskt_sel_n = !q.from_dskt;
            d.st = S_LOAD;
         end
         S_LOAD: begin
            // Data is taken only while a select is active; a dropped select stops the read.
            if (rd_valid && sel_active) begin
               d.csw.we = 1'b1;
               d.csw.addr = CS_START_ADDR + q.count[CS_ADDR_W-1:0];
               d.csw.data = rd_data;
               d.count = q.count + CS_COUNT_STEP;
               if (q.count == CS_LAST_BYTE) begin
                  d.lcr_n = 1'b1;
                  d.st = S_DESEL;
               end
            end
         end
         S_DESEL: begin
            d.disk_sel_n = 1'b1;
            d.dskt_sel_n = 1'b1;
            d.disk_armed = 1'b0;
            d.dskt_armed = 1'b0;
            d.st = S_PCB_RESET;
         end
         S_PCB_RESET: begin
            d.pcb_reset = 1'b1;
            d.st = S_PCB_START;
         end
         S_PCB_START: begin
            d.pcb_start = 1'b1;
            d.start_addr = CS_START_ADDR;
            d.st = S_CLEAR;
         end
         S_CLEAR: begin
            // Main storage load that follows is done by the loaded microcode.
            d.display = 1'b0;
            d.st = S_IDLE;
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase
      // Adapters remember a seen reset until the boot read is done.
      // This follows the state case so a reset seen while the load ends still arms.
      if (!disk_rst_s) begin
         d.disk_armed = 1'b1;
      end
      if (!por_s) begin
         d.dskt_armed = 1'b1;
      end
      // Disk adapter: one read command per boot once armed and selected.
      if (q.disk_armed && !q.disk_sel_n && !q.disk_sent) begin
         d.disk_sent = 1'b1;
         d.dcmd.valid = 1'b1;
         d.dcmd.records = DISK_RECORD_COUNT;
         d.dcmd.start_record = DISK_START_RECORD;
         d.dcmd.cylinder = DISK_START_CYL;
         d.dcmd.head = DISK_START_HEAD;
      end
      // Diskette adapter: one command per cycle in fixed order, then stop.
      if (q.dskt_armed && !q.dskt_sel_n && q.dskt_next != DSKT_CMD_NONE) begin
         d.kcmd.valid = 1'b1;
         d.kcmd.code = q.dskt_next;
         d.kcmd.cylinder = DSKT_START_CYL;
         d.kcmd.head = DSKT_START_HEAD;
         d.kcmd.sector = DSKT_START_SECTOR;
         unique case (q.dskt_next)
            DSKT_CMD_RECAL: d.dskt_next = DSKT_CMD_LOAD_HEADS;
            DSKT_CMD_LOAD_HEADS: d.dskt_next = DSKT_CMD_READ;
            DSKT_CMD_READ: d.dskt_next = DSKT_CMD_NONE;
            DSKT_CMD_NONE: d.dskt_next = DSKT_CMD_NONE;
         endcase
      end
   end

   // State register; all control lines rest at their inactive level.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.st <= S_IDLE;
         q.lcr_n <= 1'b1;
         q.disk_sel_n <= 1'b1;
         q.dskt_sel_n <= 1'b1;
         q.display <= !LOADING_SHOWN;
         q.dskt_next <= DSKT_CMD_NONE;
         q.start_addr <= CS_START_ADDR;
      end else begin
         q <= d;
      end
   end

   // Every output is a flip-flop of the state struct.
   assign load_cycle_request_n = q.lcr_n;
   assign disk_boot_select_n = q.disk_sel_n;
   assign diskette_boot_select_n = q.dskt_sel_n;
   assign cs_write = q.csw;
   assign disk_cmd = q.dcmd;
   assign dskt_cmd = q.kcmd;
   assign processor_control_bit_reset = q.pcb_reset;
   assign processor_control_bit_start = q.pcb_start;
   assign control_processor_start_addr = q.start_addr;
   assign loading_display = q.display;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence end_of_load_s;
      q.st == S_LOAD && rd_valid && sel_active && q.count == CS_LAST_BYTE;
   endsequence

   sequence tail_s;
      load_cycle_request_n ##1 (disk_boot_select_n && diskette_boot_select_n)
         ##1 processor_control_bit_reset ##1 processor_control_bit_start
         ##1 !loading_display;
   endsequence

   start_request_a: assert property (q.st == S_IDLE && load_start
      |=> !load_cycle_request_n && loading_display)
      else $error("load request not raised on start");
   select_follow_a: assert property ($fell(load_cycle_request_n)
      |=> (disk_boot_select_n != diskette_boot_select_n))
      else $error("boot select not driven after request");
   first_address_a: assert property (cs_write.we && q.count == CS_COUNT_STEP
      |-> cs_write.addr == CS_START_ADDR)
      else $error("first byte not at address zero");
   address_step_a: assert property (cs_write.we && $past(cs_write.we) && q.st == S_LOAD
      |-> cs_write.addr == $past(cs_write.addr) + 12'h001)
      else $error("control storage address skipped");
   full_count_a: assert property (end_of_load_s |=> tail_s)
      else $error("end of load tail out of order");
   request_held_a: assert property (q.st == S_LOAD && q.count != CS_LAST_BYTE
      |=> !load_cycle_request_n)
      else $error("load request dropped early");
   start_addr_a: assert property (processor_control_bit_start
      |-> control_processor_start_addr == CS_START_ADDR)
      else $error("processor start address not zero");
   disk_cmd_a: assert property (disk_cmd.valid
      |-> disk_cmd.records == DISK_RECORD_COUNT && $past(q.disk_armed)
      && !$past(disk_boot_select_n))
      else $error("disk read command malformed or unarmed");
   dskt_order_a: assert property (dskt_cmd.valid && dskt_cmd.code == DSKT_CMD_RECAL
      |=> dskt_cmd.valid && dskt_cmd.code == DSKT_CMD_LOAD_HEADS
      ##1 dskt_cmd.valid && dskt_cmd.code == DSKT_CMD_READ)
      else $error("diskette command order broken");

endmodule : boot_load_sequencer

// ==== pin_sync2.sv ====
`timescale 1ns/1ns
module pin_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Asynchronous level in, synchronised level out.
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t q;
   sync_t d;

   // The first stage feeds only the second, so metastability never reaches logic.
   always_comb begin
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   // Reset to the inactive level of the pins.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= {INIT, INIT};
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.s2;

endmodule : pin_sync2

// ==== test_boot_load_sequencer.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_boot_load_sequencer
   import boot_load_pkg::*;
;
   logic mclk, rst_n, load_start, boot_from_diskette, loading_display;
   logic disk_dskt_reset_n, power_on_reset_n, rd_valid, slow;
   logic [7:0] rd_data, seed_byte, exp_b;
   logic load_cycle_request_n, disk_boot_select_n, diskette_boot_select_n;
   logic processor_control_bit_reset, processor_control_bit_start;
   logic [CS_ADDR_W-1:0] control_processor_start_addr;
   cs_write_t cs_write;
   disk_cmd_t disk_cmd;
   dskt_cmd_word_t dskt_cmd;
   int n_mismatch, compares, wr_n, k, n_disk, cyc;
   int t_we, t_lcr, t_sel, t_rst, t_go, t_clr;
   logic lcr_prev, sel_prev, disp_prev;
   logic [7:0] exp_q[$];
   integer seed = 32'h52F8;

   boot_load_sequencer boot_load_sequencer_i (.mclk(mclk), .rst_n(rst_n),
      .load_start(load_start), .boot_from_diskette(boot_from_diskette),
      .loading_display(loading_display), .disk_dskt_reset_n(disk_dskt_reset_n),
      .power_on_reset_n(power_on_reset_n), .rd_valid(rd_valid), .rd_data(rd_data),
      .load_cycle_request_n(load_cycle_request_n), .disk_boot_select_n(disk_boot_select_n),
      .diskette_boot_select_n(diskette_boot_select_n), .cs_write(cs_write),
      .disk_cmd(disk_cmd), .dskt_cmd(dskt_cmd),
      .processor_control_bit_reset(processor_control_bit_reset),
      .processor_control_bit_start(processor_control_bit_start),
      .control_processor_start_addr(control_processor_start_addr));

   boot_drive_model boot_drive_model_i (.mclk(mclk), .rst_n(rst_n),
      .disk_boot_select_n(disk_boot_select_n), .diskette_boot_select_n(diskette_boot_select_n),
      .disk_cmd(disk_cmd), .dskt_cmd(dskt_cmd), .slow(slow), .seed_byte(seed_byte),
      .rd_valid(rd_valid), .rd_data(rd_data));

   // The clock runs at 20 MHz.
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task test_done;
      if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // Cycle count; the ceiling covers one fast and one paced load with margin.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         test_done();
      end
   end

   // Every write is checked against the queue model; tail events are timed.
   always @(negedge mclk) begin
      if (rst_n && cs_write.we) begin
         exp_b = exp_q.pop_front();
         `CHK(cs_write.addr, CS_START_ADDR + wr_n[11:0])
         `CHK(cs_write.data, exp_b)
         wr_n++;
         t_we = cyc;
      end
      if (rst_n && disk_cmd.valid) begin
         `CHK(disk_cmd, {1'b1, DISK_RECORD_COUNT, DISK_START_RECORD, DISK_START_CYL,
            DISK_START_HEAD})
         n_disk++;
      end
      if (rst_n && dskt_cmd.valid) begin
         `CHK(dskt_cmd, {1'b1, dskt_cmd_t'(k + 1), DSKT_START_CYL, DSKT_START_HEAD,
            DSKT_START_SECTOR})
         k++;
      end
      if (processor_control_bit_start) begin
         `CHK(control_processor_start_addr, CS_START_ADDR)
         t_go = cyc;
      end
      if (processor_control_bit_reset) t_rst = cyc;
      if (load_cycle_request_n && !lcr_prev) t_lcr = cyc;
      if (disk_boot_select_n && diskette_boot_select_n && !sel_prev) t_sel = cyc;
      if (!loading_display && disp_prev) t_clr = cyc;
      lcr_prev = load_cycle_request_n;
      sel_prev = disk_boot_select_n && diskette_boot_select_n;
      disp_prev = loading_display;
   end

   // Adapter reset pins are pulsed so each adapter arms before its select.
   task arm;
      disk_dskt_reset_n = 1'b0;
      power_on_reset_n = 1'b0;
      repeat (3) @(negedge mclk);
      disk_dskt_reset_n = 1'b1;
      power_on_reset_n = 1'b1;
      repeat (3) @(negedge mclk);
   endtask : arm

   // One full boot load; the start level still held in the request cycle must be ignored.
   task automatic load(input logic dskt, input logic slw);
      int w;
      boot_from_diskette = dskt;
      slow = slw;
      seed_byte = 8'($random(seed));
      wr_n = 0;
      k = 0;
      n_disk = 0;
      for (int i = 0; i < 4096; i++) exp_q.push_back(seed_byte ^ i[7:0]);
      load_start = 1'b1;
      @(negedge mclk);
      `CHK(load_cycle_request_n, 1'b0)
      `CHK(loading_display, LOADING_SHOWN)
      @(negedge mclk);
      `CHK({disk_boot_select_n, diskette_boot_select_n}, dskt ? 2'b10 : 2'b01)
      load_start = 1'b0;
      w = 0;
      while (loading_display !== 1'b0 && w < 9000) begin
         @(negedge mclk);
         w++;
      end
      if (w == 9000) n_mismatch++;
      repeat (2) @(negedge mclk);
      `CHK(wr_n, 4096)
      `CHK(exp_q.size(), 0)
      `CHK(t_lcr, t_we)
      `CHK(t_sel, t_lcr + 1)
      `CHK(t_rst, t_sel + 1)
      `CHK(t_go, t_rst + 1)
      `CHK(t_clr, t_go + 1)
      `CHK(n_disk, dskt ? 0 : 1)
      `CHK(k, dskt ? 3 : 0)
   endtask : load

   // Fast disk load, paced diskette load, then an unarmed load cut by reset.
   initial begin
      rst_n = 1'b0;
      load_start = 1'b0;
      boot_from_diskette = 1'b0;
      disk_dskt_reset_n = 1'b1;
      power_on_reset_n = 1'b1;
      slow = 1'b0;
      seed_byte = 8'h00;
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      arm();
      load(1'b0, 1'b0);
      arm();
      load(1'b1, 1'b1);
      wr_n = 0;
      n_disk = 0;
      boot_from_diskette = 1'b0;
      load_start = 1'b1;
      @(negedge mclk);
      load_start = 1'b0;
      repeat (40) @(negedge mclk);
      `CHK(n_disk, 0)
      `CHK(wr_n, 0)
      `CHK(disk_boot_select_n, 1'b0)
      rst_n = 1'b0;
      @(negedge mclk);
      `CHK({load_cycle_request_n, disk_boot_select_n, diskette_boot_select_n}, 3'h7)
      rst_n = 1'b1;
      test_done();
   end
endmodule : test_boot_load_sequencer
